// ---- logic/oss_pkg.sv ----
// Shared constants and types of the origin search sequencer
package oss_pkg;

    // Register byte offsets
    localparam logic [7:0] OSS_CTRL_OFS   = 8'h00;
    localparam logic [7:0] OSS_SEEKV_OFS  = 8'h04;
    localparam logic [7:0] OSS_CREEPV_OFS = 8'h08;
    localparam logic [7:0] OSS_RAMP_OFS   = 8'h0C;
    localparam logic [7:0] OSS_OFFSET_OFS = 8'h10;
    localparam logic [7:0] OSS_STATUS_OFS = 8'h14;
    localparam logic [7:0] OSS_CMD_OFS    = 8'h18;

    // Control field positions
    localparam int OSS_MODE_LSB    = 0;
    localparam int OSS_SEEKDIR_BIT = 4;
    localparam int OSS_SCALE_BIT   = 5;
    localparam int OSS_SRCH_CH_LSB = 8;
    localparam int OSS_ZERO_CH_LSB = 12;

    // Command bits
    localparam int OSS_CMD_ABS_BIT   = 0;
    localparam int OSS_CMD_CLRW_BIT  = 1;
    localparam int OSS_CMD_START_BIT = 2;

    // Reset values and creep velocity limits
    localparam logic [31:0] OSS_CTRL_RST   = 32'h0000_1014;
    localparam logic [15:0] OSS_SEEKV_RST  = 16'h0064;
    localparam logic [15:0] OSS_CREEPV_RST = 16'h000A;
    localparam logic [15:0] OSS_CREEPV_MIN = 16'h0001;
    localparam logic [15:0] OSS_CREEPV_MAX = 16'h00C8;
    localparam logic [31:0] OSS_RAMP_RST   = 32'h0064_0064;
    localparam logic [31:0] OSS_OFFSET_RST = 32'h0000_0000;

    // Timing
    localparam int OSS_CLK_MHZ       = 100;
    localparam int OSS_FIRST_SERVO_ENABLE_INPUT_MS = 3200;
    localparam int OSS_FIRST_SERVO_ENABLE_INPUT_CYC = OSS_FIRST_SERVO_ENABLE_INPUT_MS * 1000 * OSS_CLK_MHZ;

    // Search modes
    typedef enum logic [2:0] {
        OSS_ALT_SENSOR_EDGE     = 3'h1,
        OSS_SINGLE_PASS_MARKER  = 3'h3,
        OSS_DOUBLE_PASS_MARKER  = 3'h4,
        OSS_SENSOR_EDGE         = 3'h5,
        OSS_TEACH_IN_PLACE      = 3'h6,
        OSS_TRAVEL_LIMIT_MARKER = 3'h7
    } oss_mode_e;

    // Motion engine requests
    typedef enum logic [1:0] {
        OSS_MV_STOP   = 2'h0,
        OSS_MV_RUN    = 2'h1,
        OSS_MV_OFFSET = 2'h2
    } oss_move_e;

    // Sequencer states, one-hot
    typedef enum logic [8:0] {
        OSS_ST_IDLE   = 9'h001,
        OSS_ST_SEEK   = 9'h002,
        OSS_ST_BRAKE  = 9'h004,
        OSS_ST_LEAVE  = 9'h008,
        OSS_ST_CREEP  = 9'h010,
        OSS_ST_MARKER = 9'h020,
        OSS_ST_OFFSET = 9'h040,
        OSS_ST_SETTLE = 9'h080,
        OSS_ST_TEACH  = 9'h100
    } oss_state_e;

    // Command to the motion engine
    typedef struct packed {
        oss_move_e   move;
        logic        dir;
        logic [15:0] velocity;
        logic [15:0] ramp_up;
        logic [15:0] ramp_down;
        logic [31:0] offset;
    } oss_motion_s;

    // Feedback from the motion engine and sensors
    typedef struct packed {
        logic stopped;
        logic settled;
        logic origin_sensor;
        logic minus_limit_n;
        logic plus_limit_n;
        logic marker;
    } oss_sense_s;

endpackage

// ---- logic/oss_sequencer.sv ----
// Origin search sequencer with APB register access
`timescale 1ns/1ps

// What this block does
// - Search starts only on an off-to-on edge of search start or program launch.
// - Initial direction is seek direction combined with scale direction.
// - Motion uses search ramp-up, ramp-down and seek velocity settings.
// - Busy closed and origin defined forced open while searching.
// - Double-pass mode: sensor rise brakes to stop, then reverses out.
// - Then reverses again at creep velocity until sensor rises again.
// - Then marker, then offset move, origin defined output closes.
// - Settling at origin closes in-position and search done.
// - Interrupted search leaves origin undefined; absolute command warns.
// - Program launch with the search channel selected starts a search.
// - Sensor-edge mode sets origin at sensor rising edge.
// - Alternate sensor-edge mode also uses sensor edge, no marker.
// - Single-pass mode returns to nearest marker after sensor rise.
// - Travel-limit mode uses a limit input and marker after leaving it.
// - Minus limit on-to-off brakes, then leaves at creep velocity.
// - First marker after leaving, then offset, origin defined closes.
// - Seek direction zero searches against the plus limit.
// - Teach mode takes current position as origin, servo active only.
// - Teach completes when positioning settles; busy held meanwhile.
// - Servo active follows enable; first activation waits the long delay.
// - Zero-point program run by start command teaches with servo off.
// - Creep velocity held between 0.001 and 0.200, default 0.010.
module oss_sequencer #(
    parameter int FIRST_SERVO_ENABLE_INPUT_CYC = oss_pkg::OSS_FIRST_SERVO_ENABLE_INPUT_CYC
) (
    input  wire logic              CLK_SYS,
    input  wire logic              SYS_RST,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [7:0]        PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic [31:0]            PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    input  wire logic              SERVO_ENABLE,
    input  wire logic              SEARCH_START,
    input  wire logic              PROG_LAUNCH,
    input  wire logic [3:0]        PROG_CHANNEL,
    input  wire oss_pkg::oss_sense_s SENSE,
    output oss_pkg::oss_motion_s   MOTION,
    output logic                   SERVO_ACTIVE,
    output logic                   BUSY,
    output logic                   ORIGIN_DEFINED,
    output logic                   IN_POSITION,
    output logic                   SEARCH_DONE,
    output logic                   ORIGIN_WARNING
);
    import oss_pkg::*;

    typedef struct packed {
        oss_state_e  st;
        oss_motion_s mot;
        logic [31:0] ctrl;
        logic [15:0] seekv;
        logic [15:0] creepv;
        logic [31:0] ramp;
        logic [31:0] offset;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [31:0] servo_enable_input_cnt;
        logic        servo_enable_input_first_done;
        logic        servo_active;
        logic        busy;
        logic        origin_def;
        logic        in_pos;
        logic        done;
        logic        warn;
        logic        start_prev;
        logic        launch_prev;
        logic        sensor_prev;
        logic        limit_prev;
    } oss_state_s;

    oss_state_s s_q;
    oss_state_s s_d;

    logic        acc;
    logic        wr;
    logic        rd;
    logic [2:0]  mode;
    logic        dir0;
    logic        lim_n;
    logic        sensor_rise;
    logic        lim_trip;
    logic        lim_clear;
    logic        search_req;
    logic        zero_req;
    logic [15:0] wv;

    always_comb
    begin
        s_d = s_q;
        acc = PSEL && PENABLE;
        wr = acc && PWRITE && s_q.pready;
        rd = acc && !PWRITE && !s_q.pready;
        mode = s_q.ctrl[OSS_MODE_LSB +: 3];
        dir0 = s_q.ctrl[OSS_SEEKDIR_BIT] ^ s_q.ctrl[OSS_SCALE_BIT];
        lim_n = s_q.ctrl[OSS_SEEKDIR_BIT] ? SENSE.minus_limit_n
                                          : SENSE.plus_limit_n;
        sensor_rise = SENSE.origin_sensor && !s_q.sensor_prev;
        lim_trip = !lim_n && s_q.limit_prev;
        lim_clear = lim_n && !s_q.limit_prev;
        wv = PWDATA[15:0];

        // APB: one wait state, write lands on the pready edge
        s_d.pready = acc && !s_q.pready;
        s_d.pslverr = 1'b0;
        if (rd)
        begin
            unique case (PADDR)
                OSS_CTRL_OFS:   s_d.prdata = s_q.ctrl;
                OSS_SEEKV_OFS:  s_d.prdata = {16'h0000, s_q.seekv};
                OSS_CREEPV_OFS: s_d.prdata = {16'h0000, s_q.creepv};
                OSS_RAMP_OFS:   s_d.prdata = s_q.ramp;
                OSS_OFFSET_OFS: s_d.prdata = s_q.offset;
                OSS_STATUS_OFS: s_d.prdata = {14'h0000, 9'(s_q.st),
                    3'h0, s_q.warn, s_q.done, s_q.in_pos, s_q.origin_def,
                    s_q.busy, s_q.servo_active};
                OSS_CMD_OFS:    s_d.prdata = 32'h0000_0000;
                default:
                begin
                    s_d.prdata = 32'h0000_0000;
                    s_d.pslverr = 1'b1;
                end
            endcase
        end
        else if (acc && PWRITE && !s_q.pready)
        begin
            s_d.pslverr = !(PADDR inside {OSS_CTRL_OFS, OSS_SEEKV_OFS,
                OSS_CREEPV_OFS, OSS_RAMP_OFS, OSS_OFFSET_OFS,
                OSS_STATUS_OFS, OSS_CMD_OFS});
        end
        if (wr)
        begin
            unique case (PADDR)
                OSS_CTRL_OFS:   s_d.ctrl = PWDATA;
                OSS_SEEKV_OFS:  s_d.seekv = wv;
                OSS_CREEPV_OFS: s_d.creepv = (wv < OSS_CREEPV_MIN) ?
                    OSS_CREEPV_MIN : (wv > OSS_CREEPV_MAX) ?
                    OSS_CREEPV_MAX : wv;
                OSS_RAMP_OFS:   s_d.ramp = PWDATA;
                OSS_OFFSET_OFS: s_d.offset = PWDATA;
                default:        s_d.ctrl = s_q.ctrl;
            endcase
        end

        if (wr && PADDR == OSS_CMD_OFS && PWDATA[OSS_CMD_CLRW_BIT])
            s_d.warn = 1'b0;
        if (wr && PADDR == OSS_CMD_OFS && PWDATA[OSS_CMD_ABS_BIT]
            && !s_q.origin_def)
            s_d.warn = 1'b1;

        if (!SERVO_ENABLE)
        begin
            s_d.servo_active = 1'b0;
            s_d.servo_enable_input_cnt = 32'h0000_0000;
        end
        else if (s_q.servo_enable_input_first_done ||
                 s_q.servo_enable_input_cnt == 32'(FIRST_SERVO_ENABLE_INPUT_CYC - 1))
        begin
            s_d.servo_active = 1'b1;
            s_d.servo_enable_input_first_done = 1'b1;
        end
        else
            s_d.servo_enable_input_cnt = s_q.servo_enable_input_cnt + 32'h0000_0001;

        s_d.start_prev = SEARCH_START;
        s_d.launch_prev = PROG_LAUNCH;
        s_d.sensor_prev = SENSE.origin_sensor;
        s_d.limit_prev = lim_n;
        search_req = (SEARCH_START && !s_q.start_prev) ||
            (PROG_LAUNCH && !s_q.launch_prev &&
             PROG_CHANNEL == s_q.ctrl[OSS_SRCH_CH_LSB +: 4]);
        zero_req = (PROG_LAUNCH && !s_q.launch_prev &&
             PROG_CHANNEL == s_q.ctrl[OSS_ZERO_CH_LSB +: 4]) ||
            (wr && PADDR == OSS_CMD_OFS && PWDATA[OSS_CMD_START_BIT]);

        s_d.mot.ramp_up = s_q.ramp[15:0];
        s_d.mot.ramp_down = s_q.ramp[31:16];
        s_d.mot.offset = s_q.offset;
        s_d.in_pos = SENSE.settled && s_q.servo_active && !s_q.busy;

        unique case (s_q.st)
            OSS_ST_IDLE:
            begin
                s_d.mot.move = OSS_MV_STOP;
                if (zero_req && !s_q.servo_active)
                    s_d.origin_def = 1'b1;
                else if (search_req && s_q.servo_active)
                begin
                    s_d.busy = 1'b1;
                    s_d.origin_def = 1'b0;
                    s_d.done = 1'b0;
                    if (mode == OSS_TEACH_IN_PLACE)
                        s_d.st = OSS_ST_TEACH;
                    else
                    begin
                        s_d.st = OSS_ST_SEEK;
                        s_d.mot.move = OSS_MV_RUN;
                        s_d.mot.dir = dir0;
                        s_d.mot.velocity = s_q.seekv;
                    end
                end
            end
            OSS_ST_SEEK:
            begin
                if (mode == OSS_TRAVEL_LIMIT_MARKER)
                begin
                    if (lim_trip)
                    begin
                        s_d.st = OSS_ST_BRAKE;
                        s_d.mot.move = OSS_MV_STOP;
                    end
                end
                else if (sensor_rise)
                begin
                    if (mode == OSS_SENSOR_EDGE ||
                        mode == OSS_ALT_SENSOR_EDGE)
                    begin
                        s_d.st = OSS_ST_OFFSET;
                        s_d.mot.move = OSS_MV_OFFSET;
                    end
                    else if (mode == OSS_SINGLE_PASS_MARKER)
                    begin
                        s_d.st = OSS_ST_MARKER;
                        s_d.mot.dir = !dir0;
                        s_d.mot.velocity = s_q.creepv;
                    end
                    else
                    begin
                        s_d.st = OSS_ST_BRAKE;
                        s_d.mot.move = OSS_MV_STOP;
                    end
                end
            end
            OSS_ST_BRAKE:
            begin
                if (SENSE.stopped)
                begin
                    s_d.st = OSS_ST_LEAVE;
                    s_d.mot.move = OSS_MV_RUN;
                    s_d.mot.dir = !dir0;
                    s_d.mot.velocity =
                        (mode == OSS_TRAVEL_LIMIT_MARKER) ?
                        s_q.creepv : s_q.seekv;
                end
            end
            OSS_ST_LEAVE:
            begin
                if (mode == OSS_TRAVEL_LIMIT_MARKER)
                    s_d.st = lim_clear ? OSS_ST_MARKER : OSS_ST_LEAVE;
                else if (!SENSE.origin_sensor)
                begin
                    s_d.st = OSS_ST_CREEP;
                    s_d.mot.dir = dir0;
                    s_d.mot.velocity = s_q.creepv;
                end
            end
            OSS_ST_CREEP:
            begin
                if (sensor_rise)
                    s_d.st = OSS_ST_MARKER;
            end
            OSS_ST_MARKER:
            begin
                if (SENSE.marker)
                begin
                    s_d.st = OSS_ST_OFFSET;
                    s_d.mot.move = OSS_MV_OFFSET;
                end
            end
            OSS_ST_OFFSET:
            begin
                if (SENSE.stopped)
                begin
                    s_d.st = OSS_ST_SETTLE;
                    s_d.mot.move = OSS_MV_STOP;
                    s_d.origin_def = 1'b1;
                end
            end
            OSS_ST_SETTLE, OSS_ST_TEACH:
            begin
                s_d.origin_def = 1'b1;
                if (s_q.st == OSS_ST_TEACH)
                    s_d.st = OSS_ST_SETTLE;
                else if (SENSE.settled)
                begin
                    s_d.st = OSS_ST_IDLE;
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                    s_d.in_pos = 1'b1;
                end
            end
            default:
                s_d.st = OSS_ST_IDLE;
        endcase

        if (!SERVO_ENABLE && s_q.busy)
        begin
            s_d.st = OSS_ST_IDLE;
            s_d.busy = 1'b0;
            s_d.done = 1'b0;
            s_d.in_pos = 1'b0;
            s_d.origin_def = 1'b0;
            s_d.mot.move = OSS_MV_STOP;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            s_q <= '0;
            s_q.st <= OSS_ST_IDLE;
            s_q.mot.move <= OSS_MV_STOP;
            s_q.ctrl <= OSS_CTRL_RST;
            s_q.seekv <= OSS_SEEKV_RST;
            s_q.creepv <= OSS_CREEPV_RST;
            s_q.ramp <= OSS_RAMP_RST;
            s_q.offset <= OSS_OFFSET_RST;
            s_q.start_prev <= 1'b1;
            s_q.limit_prev <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign PRDATA = s_q.prdata;
    assign PREADY = s_q.pready;
    assign PSLVERR = s_q.pslverr;
    assign MOTION = s_q.mot;
    assign SERVO_ACTIVE = s_q.servo_active;
    assign BUSY = s_q.busy;
    assign ORIGIN_DEFINED = s_q.origin_def;
    assign IN_POSITION = s_q.in_pos;
    assign SEARCH_DONE = s_q.done;
    assign ORIGIN_WARNING = s_q.warn;

endmodule // oss_sequencer

// ---- sim/oss_seq_monitor.sv ----
// Port checks of the origin search sequencer
`timescale 1ns/1ps
module oss_seq_monitor
    import oss_pkg::*;
#(
    parameter int FIRST_SERVO_ENABLE_INPUT_CYC = 20
) (
    input wire logic                 CLK_SYS,
    input wire logic                 SYS_RST,
    input wire logic                 SERVO_ENABLE,
    input wire logic                 SEARCH_START,
    input wire oss_pkg::oss_sense_s  SENSE,
    input wire oss_pkg::oss_motion_s MOTION,
    input wire logic                 SERVO_ACTIVE,
    input wire logic                 BUSY,
    input wire logic                 ORIGIN_DEFINED,
    input wire logic                 IN_POSITION,
    input wire logic                 SEARCH_DONE,
    input wire logic                 ORIGIN_WARNING
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    sequence s_take;
        $rose(SEARCH_START) && !$past(SYS_RST) && SERVO_ACTIVE &&
            SERVO_ENABLE && !BUSY;
    endsequence
    sequence s_run;
        BUSY && !ORIGIN_DEFINED && !SEARCH_DONE;
    endsequence

    start_busy_a: assert property (s_take |=> s_run)
        else $error("search start not taken");
    busy_open_a: assert property ($rose(BUSY) |-> s_run)
        else $error("origin flag closed as busy rose");
    busy_hold_a: assert property (
        BUSY && !ORIGIN_DEFINED && SERVO_ENABLE |=> BUSY)
        else $error("busy dropped before origin defined");
    idle_start_a: assert property (
        $rose(SEARCH_START) && !SERVO_ACTIVE
        |=> !BUSY && $stable(ORIGIN_DEFINED))
        else $error("start taken with servo inactive");
    stop_define_a: assert property (
        $rose(ORIGIN_DEFINED) && BUSY
        |-> MOTION.move == OSS_MV_STOP && $past(SENSE.stopped))
        else $error("origin defined while moving");
    done_flags_a: assert property (
        $rose(SEARCH_DONE) |-> ORIGIN_DEFINED &&
        IN_POSITION && !BUSY && $past(SENSE.settled))
        else $error("done without settled origin");
    abort_clear_a: assert property (
        BUSY && !SERVO_ENABLE |-> ##[1:2]
        (!BUSY && !ORIGIN_DEFINED && MOTION.move == OSS_MV_STOP))
        else $error("abort left search running");
    warn_cause_a: assert property (
        $rose(ORIGIN_WARNING) |-> !ORIGIN_DEFINED)
        else $error("warning with origin defined");
    servo_fall_a: assert property (
        $fell(SERVO_ENABLE) |=> !SERVO_ACTIVE)
        else $error("servo active stayed after disable");
    servo_rise_a: assert property (
        $rose(SERVO_ACTIVE) |-> SERVO_ENABLE && $past(SERVO_ENABLE))
        else $error("servo active without enable");
endmodule // oss_seq_monitor

bind oss_sequencer oss_seq_monitor #(.FIRST_SERVO_ENABLE_INPUT_CYC(FIRST_SERVO_ENABLE_INPUT_CYC)) u_mon (
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .SERVO_ENABLE(SERVO_ENABLE),
    .SEARCH_START(SEARCH_START), .SENSE(SENSE), .MOTION(MOTION),
    .SERVO_ACTIVE(SERVO_ACTIVE), .BUSY(BUSY),
    .ORIGIN_DEFINED(ORIGIN_DEFINED), .IN_POSITION(IN_POSITION),
    .SEARCH_DONE(SEARCH_DONE), .ORIGIN_WARNING(ORIGIN_WARNING));

// ---- sim/oss_plant.sv ----
// Motor and sensor model on the far side of the sequencer
`timescale 1ns/1ps
module oss_plant
    import oss_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            home,
    input  oss_pkg::oss_motion_s motion,
    output oss_pkg::oss_sense_s  sense,
    output int                   pos
);
    logic [1:0] tick = 2'h0;
    int         offs = 0;
    int         still = 0;

    initial pos = 0;
    // One position step every four cycles
    always @(posedge clk)
    begin
        tick <= tick + 2'h1;
        if (home)
            pos <= 0;
        else if (motion.move == OSS_MV_RUN && tick == 2'h3)
            pos <= motion.dir ? pos - 1 : pos + 1;
        offs <= (motion.move == OSS_MV_OFFSET) ? offs + 1 : 0;
        still <= sense.stopped ? still + 1 : 0;
    end

    // Sensor area, limits active low, marker every eighth step
    always_comb
    begin
        sense.stopped = motion.move == OSS_MV_STOP || offs >= 4;
        sense.settled = still >= 2;
        sense.origin_sensor = pos <= -10 && pos >= -20;
        sense.minus_limit_n = pos > -30;
        sense.plus_limit_n = pos < 30;
        sense.marker = pos % 8 == 0;
    end
endmodule // oss_plant

// ---- sim/oss_sequencer_bench.sv ----
// Self-checking bench of the origin search sequencer
`timescale 1ns/1ps
`define CHK(nm, e, s) \
    begin samples_checked++; if ((s) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %0h seen %0h", nm, e, s); end end
module oss_sequencer_bench;
    import oss_pkg::*;
    localparam int SERVO_ENABLE_INPUT_CYC = 20;
    logic        CLK_SYS = 1'b0;
    logic        SYS_RST = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        servo_en = 1'b0;
    logic        start = 1'b0;
    logic        launch = 1'b0;
    logic        home = 1'b0;
    logic [3:0]  prog_ch = 4'h0;
    logic [31:0] lfsr = 32'hC5BA3946;
    logic [31:0] prdata, ramp, rv, ofsv;
    logic        pready, pslverr, servo_active_output, busy, odef, inpos, done, warn;
    oss_sense_s  sense;
    oss_motion_s motion;
    logic [15:0] seekv, creepv;
    logic [32:0] rexp;
    logic [32:0] rdq[$];
    int          posq[$];
    int          pos, n, ep, bad_count = 0, samples_checked = 0;
    logic [2:0]  mt[7] = '{3'h4, 3'h5, 3'h1, 3'h3, 3'h7, 3'h7, 3'h6};
    logic        sdt[7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    int          pt[7] = '{-16, -10, -10, -8, -24, 24, 0};

    oss_sequencer #(.FIRST_SERVO_ENABLE_INPUT_CYC(SERVO_ENABLE_INPUT_CYC)) u_dut (
        .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SERVO_ENABLE(servo_en),
        .SEARCH_START(start), .PROG_LAUNCH(launch),
        .PROG_CHANNEL(prog_ch), .SENSE(sense), .MOTION(motion),
        .SERVO_ACTIVE(servo_active_output), .BUSY(busy), .ORIGIN_DEFINED(odef),
        .IN_POSITION(inpos), .SEARCH_DONE(done), .ORIGIN_WARNING(warn));
    oss_plant u_plant (.clk(CLK_SYS), .home(home), .motion(motion),
        .sense(sense), .pos(pos));

    initial
        forever #5 CLK_SYS = ~CLK_SYS;

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge CLK_SYS);
        penable <= 1'b1;
        do
            @(posedge CLK_SYS);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge CLK_SYS);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rdq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic search(input int i);
        apb(1'b1, OSS_CTRL_OFS, 32'h1000 | {27'h0, sdt[i], 1'b0, mt[i]});
        home <= 1'b1;
        @(posedge CLK_SYS);
        home <= 1'b0;
        posq.push_back(pt[i]);
        // one run through the program channel
        if (i == 3)
            launch <= 1'b1;
        else
            start <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        `CHK("busy origin", 2'b10, {busy, odef})
        if (mt[i] != 3'h6)
        begin
            `CHK("dir", sdt[i], motion.dir)
            `CHK("speed", {seekv, ramp, ofsv}, {motion.velocity,
                motion.ramp_down, motion.ramp_up, motion.offset})
        end
        start <= 1'b0;
        launch <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 4000)
        begin
            if (mt[i] == 3'h3 && motion.move == OSS_MV_RUN && !motion.dir)
                `CHK("creep", creepv, motion.velocity)
            @(posedge CLK_SYS);
            n++;
        end
        `CHK("finished", 1'b1, done)
        $display("test mode %0d done", mt[i]);
    endtask

    always @(posedge CLK_SYS)
    begin
        if (psel && penable && !pwrite && pready === 1'b1 && rdq.size() > 0)
        begin
            rexp = rdq.pop_front();
            `CHK("register", rexp, {pslverr, prdata})
        end
        if ($rose(done) && posq.size() > 0)
        begin
            ep = posq.pop_front();
            `CHK("origin position", ep, pos)
            `CHK("end flags", 2'b11, {odef, inpos})
        end
    end

    initial
    begin
        #400000;
        bad_count++;
        wrap_up();
    end

    initial
    begin
        repeat (8) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        @(posedge CLK_SYS);
        rd(OSS_CTRL_OFS, {1'b0, OSS_CTRL_RST});
        rd(OSS_SEEKV_OFS, {17'h0, OSS_SEEKV_RST});
        rd(OSS_CREEPV_OFS, {17'h0, OSS_CREEPV_RST});
        rd(OSS_RAMP_OFS, {1'b0, OSS_RAMP_RST});
        rd(OSS_OFFSET_OFS, {1'b0, OSS_OFFSET_RST});
        rd(OSS_CMD_OFS, 33'h0);
        apb(1'b1, OSS_STATUS_OFS, 32'hFFFFFFFF);
        rd(OSS_STATUS_OFS, 33'h200);
        rd(8'h1C, 33'h100000000);
        for (int k = 0; k < 3; k++)
        begin
            rv = (k == 0) ? 32'h0 : (k == 1) ? 32'h1F4 : 32'h1 + rnd() % 200;
            creepv = (rv == 0) ? OSS_CREEPV_MIN :
                (rv > 200) ? OSS_CREEPV_MAX : rv[15:0];
            apb(1'b1, OSS_CREEPV_OFS, rv);
            rd(OSS_CREEPV_OFS, {17'h0, creepv});
        end
        $display("test registers done");
        seekv = 16'(rnd() % 32767 + 1);
        ramp = rnd() | 32'h00010001;
        apb(1'b1, OSS_SEEKV_OFS, {16'h0, seekv});
        apb(1'b1, OSS_RAMP_OFS, ramp);
        ofsv = -(rnd() % 1000) - 1;
        apb(1'b1, OSS_OFFSET_OFS, ofsv);
        apb(1'b1, OSS_CMD_OFS, 32'h4);
        repeat (2) @(posedge CLK_SYS);
        `CHK("zero set", 1'b1, odef)
        start <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        `CHK("ignored start", 2'b01, {busy, odef})
        start <= 1'b0;
        servo_en <= 1'b1;
        n = 0;
        while (servo_active_output !== 1'b1 && n < 200)
        begin
            @(posedge CLK_SYS);
            n++;
        end
        `CHK("servo delay", 1'b1, n >= SERVO_ENABLE_INPUT_CYC && n <= SERVO_ENABLE_INPUT_CYC + 3)
        $display("test servo done");
        for (int i = 0; i < 7; i++)
            search(i);
        apb(1'b1, OSS_CTRL_OFS, 32'h1035);
        start <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        `CHK("scaled dir", 1'b0, motion.dir)
        servo_en <= 1'b0;
        repeat (4) @(posedge CLK_SYS);
        `CHK("aborted", 3'b000, {busy, odef, servo_active_output})
        start <= 1'b0;
        apb(1'b1, OSS_CMD_OFS, 32'h1);
        rd(OSS_STATUS_OFS, 33'h220);
        apb(1'b1, OSS_CMD_OFS, 32'h2);
        rd(OSS_STATUS_OFS, 33'h200);
        // zero channel launch with servo off
        prog_ch <= 4'h1;
        launch <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        `CHK("zero launch", 1'b1, odef)
        launch <= 1'b0;
        servo_en <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        `CHK("servo again", 1'b1, servo_active_output)
        $display("test abort done");
        wrap_up();
    end
endmodule // oss_sequencer_bench
